// ===== rtl/bfps_link_if.sv
/*
 * carrier between the sequencer and the link engine.
 * assumes command fields stay stable from a command toggle to its done.
 */
`default_nettype none
interface bfps_link_if;
    logic cmd_tgl; // new command
    logic done_tgl; // command finished, chip select high again
    logic req_tgl; // engine wants a write byte or offers a read byte
    logic ack_tgl; // byte served
    logic [7:0] opcode;
    logic [23:0] addr;
    logic addr_en; // three address bytes follow the opcode
    logic dummy_en; // one dummy byte follows the address
    logic wr_en; // data phase writes
    logic fast; // run rate selected
    logic [8:0] len; // data bytes
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport seq (output cmd_tgl, opcode, addr, addr_en, dummy_en, wr_en,
                 fast, len, wdata, ack_tgl, input done_tgl, req_tgl, rdata);
    modport eng (input cmd_tgl, opcode, addr, addr_en, dummy_en, wr_en,
                 fast, len, wdata, ack_tgl, output done_tgl, req_tgl, rdata);
endinterface
`default_nettype wire

// ===== rtl/bfps_pkg.sv
/*
 * shared constants and types of the boot flash protect sequencer.
 * assumes a 10 MHz system clock and a link clock of about 166.7 MHz.
 */
`default_nettype none
package bfps_pkg;
    // ************************************************************
    // flash command opcodes
    // ************************************************************
    localparam logic [7:0] OPC_SET_LATCH = 8'h06; // set_write_latch_cmd
    localparam logic [7:0] OPC_STATUS_READ = 8'h05; // status_read_cmd
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01; // status_write_cmd
    localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
    localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OPC_FAST_READ = 8'h0b;
    localparam logic [7:0] OPC_CHIP_ERASE = 8'hc7;
    // ************************************************************
    // status byte layout
    // ************************************************************
    localparam int ST_BUSY_BIT = 0; // flash_busy_flag
    localparam int ST_LATCH_BIT = 1; // write_latch_bit
    localparam int ST_LOCK_BIT = 7; // status_lock_bit
    localparam logic [7:0] STATUS_UNPROTECT = 8'h00; // all eight bits low
    // ************************************************************
    // geometry
    // ************************************************************
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [8:0] LEN_ONE = 9'h001;
    localparam logic [8:0] LEN_NONE = 9'h000;
    localparam logic [11:0] SECTOR_MASK_LO = 12'h000;
    localparam logic [2:0] HDR_OP_ONLY = 3'h1;
    localparam logic [2:0] HDR_WITH_ADDR = 3'h4;
    localparam logic [2:0] HDR_WITH_DUMMY = 3'h5;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    // ************************************************************
    // link timing
    // ************************************************************
    localparam int LINK_PERIOD_PS = 6000;
    localparam int LINK_FREQ_KHZ = 1000000000 / LINK_PERIOD_PS;
    localparam int SLOW_FREQ_KHZ = 1420; // boot rate
    localparam int FAST_FREQ_KHZ = 30000; // run rate
    localparam int CS_GAP_NS = 200; // deselect time
    // half periods round up so the rate never exceeds nominal
    localparam int SLOW_HALF_I = (LINK_FREQ_KHZ + 2 * SLOW_FREQ_KHZ - 1) /
                                 (2 * SLOW_FREQ_KHZ);
    localparam int FAST_HALF_I = (LINK_FREQ_KHZ + 2 * FAST_FREQ_KHZ - 1) /
                                 (2 * FAST_FREQ_KHZ);
    localparam int CS_GAP_I = (CS_GAP_NS * 1000 + LINK_PERIOD_PS - 1) /
                              LINK_PERIOD_PS;
    localparam logic [7:0] SLOW_HALF = SLOW_HALF_I[7:0];
    localparam logic [7:0] FAST_HALF = FAST_HALF_I[7:0];
    localparam logic [7:0] CS_GAP = CS_GAP_I[7:0];
    localparam logic [7:0] CNT_ONE = 8'h01;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        K_READ = 2'h0,
        K_PROG = 2'h1,
        K_SECT = 2'h2,
        K_CHIP = 2'h3
    } bfps_kind_t;
    typedef enum logic [2:0] {
        S_SET_WRITE_LATCH_CMD = 3'h0,
        S_POLL = 3'h1,
        S_STATUS_WRITE_CMD = 3'h2,
        S_CMD = 3'h3,
        S_BUSY = 3'h4,
        S_IDLE = 3'h5
    } bfps_sst_t;
    typedef enum logic [2:0] {
        E_IDLE = 3'h0,
        E_LOAD = 3'h1,
        E_LOW = 3'h2,
        E_HIGH = 3'h3,
        E_WAIT = 3'h4,
        E_GAP = 3'h5
    } bfps_est_t;
endpackage
`default_nettype wire

// ===== rtl/bfps_sequencer.sv
/*
 * boot flash protect sequencer: boot unprotect, then guarded operations.
 * assumes a single-width serial nor flash on the spi pins.
 */
// Function
// [R1] mode 0, single lines, reads auto-increment
// [R2] flash reports busy in status bit 0
// [R3] flash shows write latch in bit 1
// [R4] zero protection field disables protection
// [R5] status bit 7 locks the status byte
// [R6] only one status byte per command
// [R7] assume protected, unprotect at boot
// [R8] boot: latch set, poll, write zero status
// [R9] latch set and polled before program/erase
// [R10] flash clears latch after program/erase
// [R11] fixed protocol and rates, no detection
// [R12] fixed opcodes, fast read with dummy byte
// [R13] slow rate at boot, fast afterwards
// [R14] boot flash on chip select zero
// [R15] page program max 256, 4 kb sectors
`default_nettype none
module bfps_sequencer
    import bfps_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic op_start,
    input wire logic [1:0] op_kind,
    input wire logic [23:0] op_addr,
    input wire logic [8:0] op_len,
    input wire logic [7:0] data_in,
    output logic data_take,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic op_ready,
    output logic op_done,
    output logic boot_done,
    output logic [7:0] flash_status,
    output logic spi_sck,
    output logic spi_mosi,
    input wire logic spi_miso,
    output logic boot_flash_select_n,
    output logic aux_flash_select_n
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        bfps_sst_t st;
        logic pend; // command outstanding on the link
        logic booted;
        logic fast;
        bfps_kind_t kind;
        logic [23:0] addr;
        logic [8:0] len;
        logic cmd_t, ack_t;
        logic [7:0] opcode;
        logic addr_en, dummy_en, wr_en;
        logic [8:0] clen; // data bytes of current command
        logic [7:0] wdata;
        logic done_s1, done_s2, done_s3;
        logic req_s1, req_s2, req_s3;
        logic [7:0] status; // last status byte read
        logic take, rvalid;
        logic [7:0] rdat;
        logic ready, done_p;
    } bfps_seq_t;
    // boot starts with protection assumed on [R7]
    localparam bfps_seq_t SEQ_RST = '{st: S_SET_WRITE_LATCH_CMD, kind: K_READ,
                                      default: '0};
    bfps_seq_t r_reg, r_next;
    logic done_e; // link command finished
    logic req_e; // link byte service wanted
    logic [8:0] room; // bytes left in the page
    bfps_kind_t kind_in;
    bfps_link_if lnk ();
    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        r_next = r_reg;
        kind_in = bfps_kind_t'(op_kind);
        room = PAGE_BYTES - {1'b0, op_addr[7:0]};
        r_next.take = 1'b0;
        r_next.rvalid = 1'b0;
        r_next.done_p = 1'b0;
        // synchronisers
        r_next.done_s1 = lnk.done_tgl;
        r_next.done_s2 = r_reg.done_s1;
        r_next.done_s3 = r_reg.done_s2;
        r_next.req_s1 = lnk.req_tgl;
        r_next.req_s2 = r_reg.req_s1;
        r_next.req_s3 = r_reg.req_s2;
        done_e = r_reg.done_s2 != r_reg.done_s3;
        req_e = r_reg.req_s2 != r_reg.req_s3;
        // byte service during a command
        if (req_e) begin
            r_next.ack_t = ~r_reg.ack_t;
            case (r_reg.st)
                S_POLL, S_BUSY: r_next.status = lnk.rdata; // [R6]
                S_STATUS_WRITE_CMD: r_next.wdata = STATUS_UNPROTECT; // [R4] [R8]
                S_CMD: begin
                    if (r_reg.kind == K_PROG) begin
                        r_next.wdata = data_in;
                        r_next.take = 1'b1;
                    end else begin
                        r_next.rdat = lnk.rdata;
                        r_next.rvalid = 1'b1;
                    end
                end
                default: r_next.wdata = r_reg.wdata;
            endcase
        end
        // launch the command that belongs to the state
        if (!r_reg.pend && r_reg.st != S_IDLE) begin
            r_next.pend = 1'b1;
            r_next.cmd_t = ~r_reg.cmd_t;
            r_next.addr_en = 1'b0;
            r_next.dummy_en = 1'b0;
            r_next.wr_en = 1'b0;
            r_next.clen = LEN_NONE;
            case (r_reg.st)
                S_SET_WRITE_LATCH_CMD: r_next.opcode = OPC_SET_LATCH; // [R8] [R9]
                S_POLL, S_BUSY: begin
                    r_next.opcode = OPC_STATUS_READ; // [R6]
                    r_next.clen = LEN_ONE;
                end
                S_STATUS_WRITE_CMD: begin
                    r_next.opcode = OPC_STATUS_WRITE; // [R6] [R8]
                    r_next.clen = LEN_ONE;
                    r_next.wr_en = 1'b1;
                end
                S_CMD: begin
                    r_next.addr_en = r_reg.kind != K_CHIP;
                    r_next.clen = r_reg.len;
                    case (r_reg.kind)
                        K_READ: begin
                            r_next.opcode = OPC_FAST_READ; // [R12] [R1]
                            r_next.dummy_en = 1'b1;
                        end
                        K_PROG: begin
                            r_next.opcode = OPC_PAGE_PROG; // [R15]
                            r_next.wr_en = 1'b1;
                        end
                        K_SECT: r_next.opcode = OPC_SECTOR_ERASE;
                        default: r_next.opcode = OPC_CHIP_ERASE;
                    endcase
                end
                default: r_next.opcode = r_reg.opcode;
            endcase
        end
        // advance when the link reports the command done
        if (r_reg.pend && done_e) begin
            r_next.pend = 1'b0;
            case (r_reg.st)
                S_SET_WRITE_LATCH_CMD: r_next.st = S_POLL;
                S_POLL: begin
                    // repeat until the latch reads set [R3] [R8] [R9]
                    if (r_reg.status[ST_LATCH_BIT]) begin
                        r_next.st = r_reg.booted ? S_CMD : S_STATUS_WRITE_CMD;
                    end
                end
                S_STATUS_WRITE_CMD: r_next.st = S_BUSY;
                S_CMD: begin
                    if (r_reg.kind == K_READ) begin
                        r_next.st = S_IDLE;
                        r_next.done_p = 1'b1;
                    end else begin
                        r_next.st = S_BUSY; // latch drops by itself [R10]
                    end
                end
                S_BUSY: begin
                    // wait out the internal write [R2]
                    if (!r_reg.status[ST_BUSY_BIT]) begin
                        r_next.st = S_IDLE;
                        r_next.booted = 1'b1;
                        r_next.fast = 1'b1; // [R13]
                        r_next.done_p = r_reg.booted;
                    end
                end
                default: r_next.st = S_IDLE;
            endcase
        end
        // accept a new operation
        if (r_reg.st == S_IDLE && op_start) begin
            r_next.kind = kind_in;
            r_next.addr = op_addr;
            r_next.len = LEN_NONE;
            case (kind_in)
                K_READ: r_next.len = op_len;
                K_PROG: r_next.len = (op_len > room) ? room : op_len; // [R15]
                K_SECT: r_next.addr = {op_addr[23:12], SECTOR_MASK_LO};
                default: r_next.len = LEN_NONE;
            endcase
            r_next.st = (kind_in == K_READ) ? S_CMD : S_SET_WRITE_LATCH_CMD; // [R9]
        end
        r_next.ready = r_next.st == S_IDLE;
    end
    // ************************************************************
    // register
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r_reg <= SEQ_RST;
        end else begin
            r_reg <= r_next;
        end
    end
    // ************************************************************
    // link and outputs
    // ************************************************************
    assign lnk.cmd_tgl = r_reg.cmd_t;
    assign lnk.ack_tgl = r_reg.ack_t;
    assign lnk.opcode = r_reg.opcode;
    assign lnk.addr = r_reg.addr;
    assign lnk.addr_en = r_reg.addr_en;
    assign lnk.dummy_en = r_reg.dummy_en;
    assign lnk.wr_en = r_reg.wr_en;
    assign lnk.fast = r_reg.fast;
    assign lnk.len = r_reg.clen;
    assign lnk.wdata = r_reg.wdata;
    assign data_take = r_reg.take;
    assign rd_valid = r_reg.rvalid;
    assign rd_data = r_reg.rdat;
    assign op_ready = r_reg.ready;
    assign op_done = r_reg.done_p;
    assign boot_done = r_reg.booted;
    assign flash_status = r_reg.status;
    // engine on the link clock
    bfps_spi_engine u_engine (
        .link_clk(link_clk),
        .reset(reset),
        .lnk(lnk),
        .spi_sck(spi_sck),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .boot_flash_select_n(boot_flash_select_n),
        .aux_flash_select_n(aux_flash_select_n)
    );
endmodule
`default_nettype wire

// ===== rtl/bfps_spi_engine.sv
/*
 * spi mode 0 byte engine on the link clock.
 * assumes toggles from the sequencer and stable fields around them.
 */
`default_nettype none
module bfps_spi_engine
    import bfps_pkg::*;
(
    input wire logic link_clk,
    input wire logic reset,
    bfps_link_if.eng lnk,
    output logic spi_sck,
    output logic spi_mosi,
    input wire logic spi_miso,
    output logic boot_flash_select_n,
    output logic aux_flash_select_n
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        bfps_est_t st;
        logic [7:0] cnt; // half period and gap counter
        logic [2:0] bitc; // bit within byte
        logic [7:0] sh; // shift register
        logic [8:0] idx; // data bytes done
        logic [2:0] hdr; // header bytes loaded
        logic dat; // current byte is a data byte
        logic [7:0] rdat;
        logic cmd_s1, cmd_s2, cmd_s3;
        logic ack_s1, ack_s2, ack_s3;
        logic miso_s1, miso_s2;
        logic done_t, req_t;
        logic sck, mosi, cs_n, cs1_n;
    } bfps_eng_t;
    localparam bfps_eng_t ENG_RST = '{st: E_IDLE, cs_n: 1'b1, cs1_n: 1'b1,
                                      default: '0};
    bfps_eng_t r_reg, r_next;
    logic [7:0] half; // half period of the selected rate
    logic [2:0] hdr_n; // header length of this command
    logic [7:0] hdr_byte; // header byte to send next
    logic [7:0] in_byte; // byte as it completes
    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        r_next = r_reg;
        half = lnk.fast ? FAST_HALF : SLOW_HALF; // [R13] [R11]
        hdr_n = !lnk.addr_en ? HDR_OP_ONLY :
                (lnk.dummy_en ? HDR_WITH_DUMMY : HDR_WITH_ADDR);
        // address goes most significant byte first
        case (r_reg.hdr)
            3'h0: hdr_byte = lnk.opcode;
            3'h1: hdr_byte = lnk.addr[23:16];
            3'h2: hdr_byte = lnk.addr[15:8];
            3'h3: hdr_byte = lnk.addr[7:0];
            default: hdr_byte = DUMMY_BYTE; // [R12]
        endcase
        in_byte = {r_reg.sh[6:0], r_reg.miso_s2};
        // synchronisers
        r_next.cmd_s1 = lnk.cmd_tgl;
        r_next.cmd_s2 = r_reg.cmd_s1;
        r_next.cmd_s3 = r_reg.cmd_s2;
        r_next.ack_s1 = lnk.ack_tgl;
        r_next.ack_s2 = r_reg.ack_s1;
        r_next.ack_s3 = r_reg.ack_s2;
        r_next.miso_s1 = spi_miso;
        r_next.miso_s2 = r_reg.miso_s1;
        r_next.cs1_n = 1'b1; // second select never used [R14]
        case (r_reg.st)
            // wait for a command, then select the flash
            E_IDLE: begin
                if (r_reg.cmd_s2 != r_reg.cmd_s3) begin
                    r_next.cs_n = 1'b0; // [R14]
                    r_next.hdr = 3'h0;
                    r_next.idx = 9'h000;
                    r_next.dat = 1'b0;
                    r_next.cnt = 8'h00;
                    r_next.st = E_LOAD;
                end
            end
            // pick the next byte or finish
            E_LOAD: begin
                if (r_reg.hdr < hdr_n) begin
                    r_next.sh = hdr_byte;
                    r_next.hdr = r_reg.hdr + 3'h1;
                    r_next.st = E_LOW;
                end else if (r_reg.idx == lnk.len) begin
                    r_next.cs_n = 1'b1;
                    r_next.cnt = 8'h00;
                    r_next.st = E_GAP;
                end else if (lnk.wr_en) begin
                    r_next.req_t = ~r_reg.req_t; // ask for a write byte
                    r_next.st = E_WAIT;
                end else begin
                    r_next.sh = 8'h00;
                    r_next.dat = 1'b1;
                    r_next.st = E_LOW;
                end
            end
            // clock low half, data out changes here [R1]
            E_LOW: begin
                r_next.mosi = r_reg.sh[7];
                if (r_reg.cnt == half - CNT_ONE) begin
                    r_next.cnt = 8'h00;
                    r_next.sck = 1'b1;
                    r_next.st = E_HIGH;
                end else begin
                    r_next.cnt = r_reg.cnt + CNT_ONE;
                end
            end
            // clock high half, data in sampled at its end [R1]
            E_HIGH: begin
                if (r_reg.cnt == half - CNT_ONE) begin
                    r_next.cnt = 8'h00;
                    r_next.sck = 1'b0;
                    r_next.sh = in_byte;
                    r_next.bitc = r_reg.bitc + 3'h1;
                    if (r_reg.bitc != 3'h7) begin
                        r_next.st = E_LOW;
                    end else if (r_reg.dat && !lnk.wr_en) begin
                        r_next.rdat = in_byte; // offer a read byte
                        r_next.req_t = ~r_reg.req_t;
                        r_next.st = E_WAIT;
                    end else begin
                        r_next.st = E_LOAD;
                    end
                end else begin
                    r_next.cnt = r_reg.cnt + CNT_ONE;
                end
            end
            // clock parked low until the byte is served
            E_WAIT: begin
                if (r_reg.ack_s2 != r_reg.ack_s3) begin
                    r_next.idx = r_reg.idx + 9'h001;
                    if (lnk.wr_en) begin
                        r_next.sh = lnk.wdata;
                        r_next.dat = 1'b1;
                        r_next.st = E_LOW;
                    end else begin
                        r_next.st = E_LOAD;
                    end
                end
            end
            // deselect time before reporting done
            E_GAP: begin
                if (r_reg.cnt == CS_GAP - CNT_ONE) begin
                    r_next.done_t = ~r_reg.done_t;
                    r_next.st = E_IDLE;
                end else begin
                    r_next.cnt = r_reg.cnt + CNT_ONE;
                end
            end
            default: r_next.st = E_IDLE;
        endcase
    end
    // ************************************************************
    // register
    // ************************************************************
    always_ff @(posedge link_clk or posedge reset) begin
        if (reset) begin
            r_reg <= ENG_RST;
        end else begin
            r_reg <= r_next;
        end
    end
    assign spi_sck = r_reg.sck;
    assign spi_mosi = r_reg.mosi;
    assign boot_flash_select_n = r_reg.cs_n;
    assign aux_flash_select_n = r_reg.cs1_n;
    assign lnk.done_tgl = r_reg.done_t;
    assign lnk.req_tgl = r_reg.req_t;
    assign lnk.rdata = r_reg.rdat;
endmodule
`default_nettype wire

// ===== tb/bfps_checker.sv
/* timing checks on the sequencer ports.
   assumes it is bound into every sequencer instance. */
`default_nettype none
module bfps_checker(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic op_start,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic boot_done,
    input wire logic data_take,
    input wire logic spi_sck,
    input wire logic spi_mosi,
    input wire logic boot_flash_select_n,
    input wire logic aux_flash_select_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // link side
    // ************************************************************
    aux_idle_a: assert property (@(posedge link_clk)
        disable iff (reset) aux_flash_select_n)
        else $error("aux select active");
    sck_parks_a: assert property (@(posedge link_clk)
        disable iff (reset) boot_flash_select_n |-> !spi_sck)
        else $error("sck off frame");
    mosi_hold_a: assert property (@(posedge link_clk)
        disable iff (reset) spi_sck && $past(spi_sck) |-> $stable(spi_mosi))
        else $error("mosi moved while sck high");
    fast_high_a: assert property (@(posedge link_clk)
        disable iff (reset) boot_done && $rose(spi_sck) |->
        spi_sck [*3] ##1 !spi_sck) else $error("fast high phase wrong");
    // ************************************************************
    // user side
    // ************************************************************
    ready_drop_a: assert property (@(posedge sys_clk)
        disable iff (reset) op_start && op_ready |=> !op_ready)
        else $error("start not taken");
    done_ready_a: assert property (@(posedge sys_clk)
        disable iff (reset) op_done |-> op_ready && boot_done)
        else $error("done not idle");
    boot_first_a: assert property (@(posedge sys_clk)
        disable iff (reset) op_ready |-> boot_done)
        else $error("ready before boot");
    take_busy_a: assert property (@(posedge sys_clk)
        disable iff (reset) data_take |-> !op_ready ##1 !data_take)
        else $error("take misplaced");
endmodule
bind bfps_sequencer bfps_checker chk (.*);
`default_nettype wire

// ===== tb/bfps_flash_model.sv
/* behavioural single-width serial nor flash, mode 0.
   assumes sck idles low and cs_n frames every command. */
`default_nettype none
module bfps_flash_model(
    input wire logic sck,
    input wire logic mosi,
    input wire logic cs_n,
    output logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] st = 8'h9c; // protected at power up, lock set
    logic [7:0] sh, cmd, o, last_dat; // last_dat: final page data byte
    logic [23:0] a;
    int nb, nbit, busy, n_dat, bad, n_chip;
    initial miso = 1'b0;
    // frame start
    always @(negedge cs_n) begin
        nb = 0;
        nbit = 0;
    end
    // command takes effect when the frame closes
    always @(posedge cs_n) begin
        miso = ~miso; // released line shows no stale bit
        if (cmd == 8'h06) st[1] = 1'b1;
        if (cmd inside {8'h02, 8'h20, 8'hc7} && st[1]) begin
            st[0] = 1'b1;
            busy = 3;
        end
        if (cmd == 8'hc7 && st[1]) n_chip++;
        if (cmd == 8'h05 && busy > 0) begin
            busy--;
            if (busy == 0) st[1:0] = 2'b00;
        end
    end
    // shift in, msb first
    always @(posedge sck) if (!cs_n) begin
        sh = {sh[6:0], mosi};
        nbit++;
        if (nbit == 8) begin
            nbit = 0;
            nb++;
            if (nb == 1) begin
                cmd = sh;
                if (cmd == 8'h02) n_dat = 0;
                if (cmd inside {8'h01, 8'h02, 8'h20, 8'hc7} && !st[1]) bad++;
            end else if (nb < 5 && cmd inside {8'h02, 8'h20, 8'h0b})
                a = {a[15:0], sh};
            else if (cmd == 8'h02) begin
                n_dat++;
                last_dat = sh;
            end
            // one status byte only; lock and protect bits stored
            if (cmd == 8'h01 && nb == 2 && st[1]) begin
                st = {sh[7:2], 2'b11};
                busy = 3;
            end
        end
    end
    // shift out after sck falls; reads auto-increment
    always @(negedge sck) if (!cs_n) begin
        if (nbit == 0)
            o = cmd == 8'h0b ? (a[7:0] + nb[7:0] - 8'h05) ^ 8'h5a : st;
        miso = o[7 - nbit];
    end
endmodule
`default_nettype wire

// ===== tb/boot_flash_protect_sequencer_bench.sv
/* self-checking bench of the boot flash sequencer.
   assumes the flash model and the bound checker. */
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error %0t %h %h", $time, a, b); end end
module boot_flash_protect_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import bfps_pkg::*;
    logic sys_clk = 0, link_clk = 0, reset = 1, op_start = 0;
    logic [1:0] op_kind = 0;
    logic [23:0] op_addr = 0;
    logic [8:0] op_len = 0;
    logic [7:0] data_in = 0;
    wire logic data_take, rd_valid, op_ready, op_done, boot_done, spi_sck;
    wire logic spi_mosi, spi_miso, boot_flash_select_n, aux_flash_select_n;
    wire logic [7:0] rd_data, flash_status;
    int n_errors = 0, total_checks = 0, takes, n_rd;
    bfps_sequencer DUT (.sys_clk, .reset, .link_clk, .op_start, .op_kind,
        .op_addr, .op_len, .data_in, .data_take, .rd_valid, .rd_data,
        .op_ready, .op_done, .boot_done, .flash_status, .spi_sck,
        .spi_mosi, .spi_miso, .boot_flash_select_n, .aux_flash_select_n);
    bfps_flash_model flash (.sck(spi_sck), .mosi(spi_mosi),
        .cs_n(boot_flash_select_n), .miso(spi_miso));
    initial forever #50 sys_clk = ~sys_clk;
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    // one user operation; rep adds a refused second start
    task automatic run_op(input logic [1:0] k, input logic [23:0] ad,
                          input logic [8:0] ln, input logic rep);
        int t;
        t = 0; takes = 0; n_rd = 0; data_in = 8'h00;
        while (op_ready !== 1'b1) begin @(posedge sys_clk); #1; end
        op_kind = k; op_addr = ad; op_len = ln; op_start = 1'b1;
        @(posedge sys_clk); #1 op_start = rep; op_kind = 2'h3;
        @(posedge sys_clk); #1 op_start = 1'b0;
        do begin
            @(posedge sys_clk); #1 t++;
            if (data_take === 1'b1) begin takes++; data_in = takes[7:0]; end
            if (rd_valid === 1'b1) begin
                `CHK(rd_data, (ad[7:0] + n_rd[7:0]) ^ 8'h5a)
                n_rd++;
            end
        end while (op_done !== 1'b1 && t < 20000);
        `CHK(op_done, 1'b1)
    endtask
    task automatic t_boot;
        int t;
        t = 0;
        while (boot_done !== 1'b1 && t < 20000) begin
            @(posedge sys_clk);
            #1 t++;
        end
        `CHK(boot_done, 1'b1)
        `CHK(flash_status, 8'h00)
        `CHK(flash.st, 8'h00)
        `CHK(flash.bad, 0)
    endtask
    task automatic t_read;
        run_op(K_READ, 24'h0001fe, 9'h004, 1'b0);
        `CHK(n_rd, 4)
        `CHK(flash.cmd, 8'h0b)
    endtask
    task automatic t_prog;
        run_op(K_PROG, 24'h0003f0, 9'h020, 1'b1);
        `CHK(takes, 16)
        `CHK(flash.n_dat, 16)
        `CHK(flash.last_dat, 8'h0f)
        `CHK(flash.a, 24'h0003f0)
        `CHK(flash.st[1], 1'b0)
        `CHK(flash.n_chip, 0)
    endtask
    task automatic t_erase;
        run_op(K_SECT, 24'h012345, 9'h000, 1'b0);
        `CHK(flash.a, 24'h012000)
        run_op(K_CHIP, 24'h000000, 9'h000, 1'b0);
        `CHK(flash.n_chip, 1)
        `CHK(flash.bad, 0)
    endtask
    task results;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_boot;
        t_read;
        t_prog;
        t_erase;
        results;
    end
    initial begin
        #2000000;
        n_errors++;
        results;
    end
endmodule
`default_nettype wire
